/* logic/uart_fc_pkg.sv */
// package of constants and carrier types for the flow-controlled serial port
`default_nettype none
package uart_fc_pkg;
  // ----------------------------------------
  // frame layout
  // ----------------------------------------
  localparam int DATA_BITS = 8;
  localparam int BIT_IDX_W = 3;
  localparam logic [BIT_IDX_W-1:0] LAST_BIT = 3'h7;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic START_LEVEL = 1'b0;
  localparam logic STOP_LEVEL = 1'b1;
  // ----------------------------------------
  // baud generator
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int MAX_BAUD = 1_000_000;
  localparam int DIV_W = 16;
  // smallest divisor allowed: 1 Mbps at 50 MHz
  localparam logic [DIV_W-1:0] MIN_DIV = DIV_W'(CLK_HZ / MAX_BAUD);
  // reset divisor gives 115200 baud
  localparam logic [DIV_W-1:0] RESET_DIV = DIV_W'(CLK_HZ / 115_200);
  // flow control levels: asserted means low on the wire
  localparam logic FLOW_ON = 1'b0;
  localparam logic FLOW_OFF = 1'b1;

  typedef enum logic [1:0] {
    PHASE_START,
    PHASE_DATA,
    PHASE_PARITY,
    PHASE_STOP
  } phase_t;

  // configuration applied to both directions
  typedef struct packed {
    logic [DIV_W-1:0] divisor;
    logic parity_even;
    logic flow_enable;
  } cfg_t;

  // a received byte with its error flags
  typedef struct packed {
    logic [DATA_BITS-1:0] data;
    logic parity_err;
    logic frame_err;
  } rx_word_t;
endpackage
`default_nettype wire

/* logic/uart_fc.sv */
// serial transmitter and receiver with optional request/clear-to-send flow control
// Overview of operation
// RL1 - data bits go out and come in least significant bit first
// RL2 - eight data bits, one stop bit; reset setting is eight, no parity, one stop
// RL3 - parity is either absent or one even bit after the data
// RL4 - divisor sets any bit rate, limited to at most 1 Mbps
// RL5 - flow control selectable; when off, rts and cts are ignored
// RL6 - rts goes to the off level whenever the receiver cannot accept data
// RL7 - pins are transmit out, receive in, request-to-send out, clear-to-send in
// RL8 - with flow control, a new frame starts only while cts is asserted
`default_nettype none
module uart_fc (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire uart_fc_pkg::cfg_t cfg,
  input wire logic power_save,
  input wire logic [uart_fc_pkg::DATA_BITS-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output uart_fc_pkg::rx_word_t rx_word,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic txd, // RL7
  input wire logic rxd,
  output logic rts_n,
  input wire logic cts_n
);
  // ----------------------------------------
  // baud divisor with clamp
  // ----------------------------------------
  logic [uart_fc_pkg::DIV_W-1:0] div;
  logic [uart_fc_pkg::DIV_W-1:0] half_div;

  // divisors below the minimum are raised so the rate never exceeds 1 Mbps
  always_comb begin
    div = (cfg.divisor < uart_fc_pkg::MIN_DIV) ? uart_fc_pkg::MIN_DIV : cfg.divisor; // RL4
    half_div = div >> 1;
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  // transmitter state; parity setting is latched per frame
  logic tx_busy;
  uart_fc_pkg::phase_t tx_phase;
  logic [uart_fc_pkg::DIV_W-1:0] tx_cnt;
  logic [uart_fc_pkg::BIT_IDX_W-1:0] tx_idx;
  logic [uart_fc_pkg::DATA_BITS-1:0] tx_shift;
  logic tx_par;
  logic tx_par_en;
  logic tx_tick;
  logic cts_ok;

  // ready only while idle and, with flow control on, while the peer clears us to send
  assign cts_ok = !cfg.flow_enable || (cts_n == uart_fc_pkg::FLOW_ON); // RL5 RL8
  assign tx_ready = !tx_busy && cts_ok; // RL8
  assign tx_tick = (tx_cnt == div - uart_fc_pkg::DIV_W'(1));

  // bit timer for the transmitter
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_cnt <= '0;
    end else if (!tx_busy || tx_tick) begin
      tx_cnt <= '0;
    end else begin
      tx_cnt <= tx_cnt + uart_fc_pkg::DIV_W'(1);
    end
  end

  // transmit sequencing: start, data lsb first, optional parity, one stop
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_busy <= 1'b0;
      tx_phase <= uart_fc_pkg::PHASE_START;
      tx_idx <= '0;
      tx_shift <= '0;
      tx_par <= 1'b0;
      tx_par_en <= 1'b0;
      txd <= uart_fc_pkg::LINE_IDLE;
    end else if (!tx_busy) begin
      txd <= uart_fc_pkg::LINE_IDLE;
      if (tx_valid && tx_ready) begin
        tx_busy <= 1'b1;
        tx_phase <= uart_fc_pkg::PHASE_START;
        tx_shift <= tx_data;
        tx_par <= ^tx_data; // even parity bit
        tx_par_en <= cfg.parity_even; // latched per frame
        tx_idx <= '0;
        txd <= uart_fc_pkg::START_LEVEL;
      end
    end else if (tx_tick) begin
      unique case (tx_phase)
        uart_fc_pkg::PHASE_START: begin
          tx_phase <= uart_fc_pkg::PHASE_DATA;
          txd <= tx_shift[0]; // RL1
        end
        uart_fc_pkg::PHASE_DATA: begin
          if (tx_idx == uart_fc_pkg::LAST_BIT) begin
            if (tx_par_en) begin
              tx_phase <= uart_fc_pkg::PHASE_PARITY;
              txd <= tx_par; // RL3
            end else begin
              tx_phase <= uart_fc_pkg::PHASE_STOP;
              txd <= uart_fc_pkg::STOP_LEVEL; // RL2
            end
          end else begin
            tx_idx <= tx_idx + uart_fc_pkg::BIT_IDX_W'(1);
            tx_shift <= tx_shift >> 1; // RL1
            txd <= tx_shift[1];
          end
        end
        uart_fc_pkg::PHASE_PARITY: begin
          tx_phase <= uart_fc_pkg::PHASE_STOP;
          txd <= uart_fc_pkg::STOP_LEVEL; // RL2
        end
        uart_fc_pkg::PHASE_STOP: begin
          tx_busy <= 1'b0; // exactly one stop bit
          txd <= uart_fc_pkg::LINE_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  // receiver state; parity setting is latched at start detect
  logic rx_busy;
  uart_fc_pkg::phase_t rx_phase;
  logic [uart_fc_pkg::DIV_W-1:0] rx_cnt;
  logic [uart_fc_pkg::BIT_IDX_W-1:0] rx_idx;
  logic [uart_fc_pkg::DATA_BITS-1:0] rx_shift;
  logic rx_par;
  logic rx_par_err;
  logic rx_par_en;
  logic rx_sample;

  // one sample strobe per bit period, the first near the middle of the start bit
  assign rx_sample = (rx_cnt == div - uart_fc_pkg::DIV_W'(1));

  // off whenever the holding word is full and not being read, or the block is in power save
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rts_n <= uart_fc_pkg::FLOW_OFF;
    end else if (!cfg.flow_enable) begin
      rts_n <= uart_fc_pkg::FLOW_OFF; // RL5
    end else begin
      rts_n <= (power_save || (rx_valid && !rx_ready)) ? uart_fc_pkg::FLOW_OFF : uart_fc_pkg::FLOW_ON; // RL6
    end
  end

  // receive timer: first sample at mid start bit, then once per bit
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_cnt <= '0;
    end else if (!rx_busy) begin
      rx_cnt <= half_div;
    end else if (rx_sample) begin
      rx_cnt <= '0;
    end else begin
      rx_cnt <= rx_cnt + uart_fc_pkg::DIV_W'(1);
    end
  end

  // receive sequencing and capture into the holding word
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_busy <= 1'b0;
      rx_phase <= uart_fc_pkg::PHASE_START;
      rx_idx <= '0;
      rx_shift <= '0;
      rx_par <= 1'b0;
      rx_par_err <= 1'b0;
      rx_par_en <= 1'b0;
      rx_word <= '0;
      rx_valid <= 1'b0;
    end else begin
      if (rx_valid && rx_ready) begin
        rx_valid <= 1'b0;
      end
      if (!rx_busy) begin
        if (rxd == uart_fc_pkg::START_LEVEL) begin
          rx_busy <= 1'b1;
          rx_phase <= uart_fc_pkg::PHASE_START;
          rx_par_en <= cfg.parity_even;
          rx_par_err <= 1'b0;
        end
      end else if (rx_sample) begin
        unique case (rx_phase)
          uart_fc_pkg::PHASE_START: begin
            if (rxd == uart_fc_pkg::START_LEVEL) begin
              rx_phase <= uart_fc_pkg::PHASE_DATA;
              rx_idx <= '0;
              rx_par <= 1'b0;
            end else begin
              rx_busy <= 1'b0; // glitch, not a start bit
            end
          end
          uart_fc_pkg::PHASE_DATA: begin
            rx_shift <= {rxd, rx_shift[uart_fc_pkg::DATA_BITS-1:1]}; // RL1
            rx_par <= rx_par ^ rxd;
            if (rx_idx == uart_fc_pkg::LAST_BIT) begin
              rx_phase <= rx_par_en ? uart_fc_pkg::PHASE_PARITY : uart_fc_pkg::PHASE_STOP; // RL3
            end else begin
              rx_idx <= rx_idx + uart_fc_pkg::BIT_IDX_W'(1);
            end
          end
          uart_fc_pkg::PHASE_PARITY: begin
            rx_par_err <= rx_par ^ rxd; // RL3
            rx_phase <= uart_fc_pkg::PHASE_STOP;
          end
          uart_fc_pkg::PHASE_STOP: begin
            rx_busy <= 1'b0; // RL2
            rx_word.data <= rx_shift;
            rx_word.parity_err <= rx_par_err;
            rx_word.frame_err <= (rxd != uart_fc_pkg::STOP_LEVEL);
            rx_valid <= 1'b1; // an unread word is overwritten
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* tb/uart_fc_props.sv */
// assertions on the serial port pins and handshakes
`default_nettype none
module uart_fc_props (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire uart_fc_pkg::cfg_t cfg,
  input wire logic power_save,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire uart_fc_pkg::rx_word_t rx_word,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic txd,
  input wire logic rts_n,
  input wire logic cts_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_start; tx_valid && tx_ready |=> (!txd && !tx_ready) [*8]; endproperty
  a_start: assert property (p_start) else $error("start bit");
  property p_cts; cfg.flow_enable && cts_n |-> !tx_ready; endproperty
  a_cts: assert property (p_cts) else $error("cts ignored");
  property p_idle; tx_ready |-> txd; endproperty
  a_idle: assert property (p_idle) else $error("idle level");
  property p_noflow; !cfg.flow_enable && $past(!cfg.flow_enable) |-> rts_n; endproperty
  a_noflow: assert property (p_noflow) else $error("rts unused");
  property p_ps; cfg.flow_enable && power_save |=> rts_n; endproperty
  a_ps: assert property (p_ps) else $error("rts in power save");
  property p_full; cfg.flow_enable && rx_valid && !rx_ready |=> rts_n; endproperty
  a_full: assert property (p_full) else $error("rts when full");
  property p_hold; rx_valid && !rx_ready |=> rx_valid && $stable(rx_word); endproperty
  a_hold: assert property (p_hold) else $error("rx word lost");
  property p_bit; $changed(txd) |=> $stable(txd) [*8]; endproperty
  a_bit: assert property (p_bit) else $error("bit too short");
  // cycles the serial output has held its level; starts saturated so reset counts as a long idle
  logic txd_q;
  logic [15:0] run_len;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      txd_q <= 1'b1;
      run_len <= 16'hffff;
    end else begin
      txd_q <= txd;
      if (txd != txd_q) begin
        run_len <= 16'h0001;
      end else if (run_len != 16'hffff) begin
        run_len <= run_len + 16'h0001;
      end
    end
  end
  property p_rate; txd != txd_q |-> run_len >= uart_fc_pkg::MIN_DIV; endproperty
  a_rate: assert property (p_rate) else $error("bit faster than the top rate");
endmodule
`default_nettype wire

/* tb/uart_peer.sv */
// serial peer model driving rxd and decoding txd
`default_nettype none
module uart_peer #(parameter int DIV = 50) (
  input wire logic core_clk,
  input wire logic txd,
  input wire logic rts_n,
  input wire logic flow,
  input wire logic par,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] got[$];
  initial rxd = 1'b1;
  // one frame on rxd, lsb first; bad flips the parity bit
  task automatic send(input logic [7:0] d, input logic bad);
    logic [10:0] f;
    while (flow && rts_n) @(posedge core_clk);
    f = {1'b1, par ? ^d ^ bad : 1'b1, d, 1'b0};
    for (int i = 0; i < 10 + par; i++) begin
      rxd <= f[i];
      repeat (DIV) @(posedge core_clk);
    end
  endtask
  // sample txd mid bit, keep stop, parity and data
  initial forever begin
    logic [9:0] w;
    @(negedge txd);
    repeat (DIV / 2) @(posedge core_clk);
    for (int i = 0; i < 10; i++) begin
      if (i != 8 || par) repeat (DIV) @(posedge core_clk);
      w[i] = (i == 8 && !par) ? ^w[7:0] : txd;
    end
    got.push_back(w);
  end
endmodule
`default_nettype wire

/* tb/uart_with_flow_control_bench.sv */
// self-checking bench for the flow-controlled serial port
`default_nettype none
module uart_with_flow_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic power_save = 1'b0;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b1;
  logic cts_n = 1'b1;
  logic [7:0] tx_data = 8'h00;
  uart_fc_pkg::cfg_t cfg = '{16'h0032, 1'b0, 1'b0};
  logic tx_ready, rx_valid, txd, rxd, rts_n;
  uart_fc_pkg::rx_word_t rx_word;
  logic [9:0] q[$];
  logic [31:0] seed = 32'hc660;
  int miscompares = 0;
  int compares = 0;
  always #10 core_clk = ~core_clk;
  uart_fc dut(.core_clk, .reset_n, .cfg, .power_save, .tx_data, .tx_valid, .tx_ready,
    .rx_word, .rx_valid, .rx_ready, .txd, .rxd, .rts_n, .cts_n);
  uart_peer #(.DIV(50)) peer(.core_clk, .txd, .rts_n, .flow(cfg.flow_enable),
    .par(cfg.parity_even), .rxd);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [9:0] frame(input logic [7:0] d);
    return {1'b1, ^d, d};
  endfunction
  // random consumer readiness
  always @(posedge core_clk) #1 rx_ready = 1'(rnd());
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // offer one byte and hold it until the edge that takes it
  task automatic put(input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    #1 tx_data = d;
    tx_valid = 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (tx_ready !== 1'b1 && n < 2000);
    if (tx_ready !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED %0t byte never taken", $time);
    end
    #1 tx_valid = 1'b0;
  endtask
  task automatic get(input logic [9:0] exp);
    for (int n = 0; n < 2000 && rx_valid !== 1'b1; n++) @(negedge core_clk);
    if (rx_valid !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED %0t no word received", $time);
    end
    chk(rx_word, exp);
  endtask
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // no parity then even parity, both directions
  initial begin
    logic [7:0] b;
    repeat (4) @(posedge core_clk);
    #1 reset_n = 1'b1;
    for (int p = 0; p < 2; p++) begin
      @(posedge core_clk);
      #1 cfg.parity_even = p[0];
      for (int e = 0; e <= p; e++) begin
        b = 8'(rnd());
        fork
          peer.send(b, e[0]);
          get({b, e[0], 1'b0});
        join
      end
      for (int i = 0; i < 3; i++) begin
        b = 8'(rnd());
        q.push_back(frame(b));
        put(b);
      end
      repeat (600) @(posedge core_clk);
    end
    // flow on: cts holds off sending, power save raises rts, a too small divisor is clamped
    #1 cfg.flow_enable = 1'b1;
    cfg.divisor = 16'h0020;
    power_save = 1'b1;
    tx_data = 8'h5a;
    tx_valid = 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chk({7'h00, txd, tx_ready, rts_n}, 10'h005);
    power_save = 1'b0;
    cts_n = 1'b0;
    q.push_back(frame(8'h5a));
    @(posedge core_clk);
    #1 tx_valid = 1'b0;
    chk({8'h00, txd, rts_n}, 10'h000);
    b = 8'(rnd());
    fork
      peer.send(b, 1'b0);
      get({b, 2'b00});
    join
    repeat (600) @(posedge core_clk);
    foreach (q[i]) chk(peer.got[i], q[i]);
    chk(10'(peer.got.size()), 10'(q.size()));
    end_sim();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    end_sim();
  end
endmodule
bind uart_fc uart_fc_props props(.core_clk, .reset_n, .cfg, .power_save, .tx_valid, .tx_ready,
  .rx_word, .rx_valid, .rx_ready, .txd, .rts_n, .cts_n);
`default_nettype wire
